/* core/usb2_tuning_pkg.sv */
// Purpose: constants for the usb2 high-speed rx/tx tuning registers
// Assumes: 8-bit registers at byte offsets, one clock domain
// Notes: code 000 of the squelch field has no threshold and maps to 0 mV
package usb2_tuning_pkg;
    localparam logic [7:0] RX_TUNING_ADDR = 8'h06;
    localparam logic [7:0] TX_EMPHASIS_ADDR = 8'h07;
    localparam logic [7:0] RX_TUNING_RESET = 8'h50;
    localparam logic [7:0] TX_EMPHASIS_RESET = 8'h00;
    // only these bits are storable; the rest are read_as_zero
    localparam logic [7:0] RX_WRITE_MASK = 8'h77;
    localparam logic [7:0] TX_WRITE_MASK = 8'h37;
    localparam int SQ_LSB = 4;
    localparam int SQ_MSB = 6;
    localparam int EQ_LSB = 0;
    localparam int EQ_MSB = 2;
    localparam int DUR_LSB = 4;
    localparam int DUR_MSB = 5;
    localparam int LVL_LSB = 0;
    localparam int LVL_MSB = 2;
    localparam logic [7:0] SQ_HYST_MV = 8'h0A;
    localparam logic [2:0] EQ_MAX_CODE = 3'h4;
    localparam logic [2:0] LVL_MAX_CODE = 3'h6;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [2:0] ZERO_CODE = 3'h0;

    typedef enum logic [1:0] {
        DUR_NONE = 2'h0,
        DUR_HALF_UI = 2'h1,
        DUR_08_UI = 2'h2,
        DUR_RESERVED = 2'h3
    } dur_code_t;

    function automatic logic [7:0] squelch_mv(input logic [2:0] code);
        logic [7:0] mv;
        mv = 8'h00;
        case (code)
            3'h1: mv = 8'h41;
            3'h2: mv = 8'h55;
            3'h3: mv = 8'h5F;
            3'h4: mv = 8'h6E;
            3'h5: mv = 8'h7D;
            3'h6: mv = 8'h8C;
            3'h7: mv = 8'h9B;
            default: mv = 8'h00;
        endcase
        return mv;
    endfunction
endpackage

/* core/usb2_hs_rx_tx_tuning_regs.sv */
// Overview of operation
// - squelch code bits 6:4, 65-155 mV, reset 101
// - equalization bits 2:0, 1 dB steps, reset 000
// - de-emphasis duration bits 5:4: none, 0.5, 0.8
// - de-emphasis level bits 2:0, 0 to 6 dB
// - repeated bits are sent at reduced amplitude
// - alternating bits are sent at full swing
// - rx settings act only in high speed
// - squelch falls 10 mV below its rising trip
//
// Purpose: rx squelch/equalization and tx de-emphasis tuning registers
// Assumes: register strobes come from the i2c target on mclk_i; hs_mode_i on same clock
// Notes: analogue settings leave as codes and millivolt figures for the drivers
`timescale 1ns/1ps
module usb2_hs_rx_tx_tuning_regs
    import usb2_tuning_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic hs_mode_i,
    input wire logic tx_bit_i,
    input wire logic tx_bit_valid_i,
    output logic [7:0] sq_rise_mv_o,
    output logic [7:0] sq_fall_mv_o,
    output logic [2:0] eq_gain_o,
    output logic [1:0] deemph_dur_o,
    output logic [2:0] deemph_db_o,
    output logic tx_deemph_o
);
    logic [7:0] rx_tuning;
    logic [7:0] tx_emphasis;
    logic prev_bit;
    logic have_prev;

    wire rx_sel = (reg_addr_i == RX_TUNING_ADDR);
    wire tx_sel = (reg_addr_i == TX_EMPHASIS_ADDR);
    wire wr_rx = ce_i && reg_wr_i && rx_sel;
    wire wr_tx = ce_i && reg_wr_i && tx_sel;
    wire [7:0] next_rx = reg_wdata_i & RX_WRITE_MASK;
    wire [7:0] next_tx = reg_wdata_i & TX_WRITE_MASK;
    wire [7:0] next_rdata = rx_sel ? rx_tuning : (tx_sel ? tx_emphasis : ZERO_BYTE);

    wire [2:0] sq_code = rx_tuning[SQ_MSB:SQ_LSB];
    wire [2:0] eq_code = rx_tuning[EQ_MSB:EQ_LSB];
    wire [1:0] dur_code = tx_emphasis[DUR_MSB:DUR_LSB];
    wire [2:0] lvl_code = tx_emphasis[LVL_MSB:LVL_LSB];
    wire [7:0] sq_rise = squelch_mv(sq_code);
    // a reserved code yields no trip level, so no hysteresis offset either
    wire [7:0] sq_fall = (sq_rise > SQ_HYST_MV) ? sq_rise - SQ_HYST_MV : ZERO_BYTE;
    // reserved duration and level codes disable reduction rather than guess
    wire dur_valid = (dur_code == DUR_HALF_UI) || (dur_code == DUR_08_UI);
    wire lvl_valid = (lvl_code != ZERO_CODE) && (lvl_code <= LVL_MAX_CODE);
    wire deemph_on = hs_mode_i && dur_valid && lvl_valid;
    wire repeat_bit = have_prev && (tx_bit_i == prev_bit);
    wire next_deemph = deemph_on && repeat_bit;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_tuning <= RX_TUNING_RESET;
        end else if (wr_rx) begin
            rx_tuning <= next_rx;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_emphasis <= TX_EMPHASIS_RESET;
        end else if (wr_tx) begin
            tx_emphasis <= next_tx;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= ZERO_BYTE;
        end else if (ce_i && reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // rx settings are forced to neutral outside high speed
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sq_rise_mv_o <= ZERO_BYTE;
            sq_fall_mv_o <= ZERO_BYTE;
            eq_gain_o <= ZERO_CODE;
        end else if (ce_i) begin
            sq_rise_mv_o <= hs_mode_i ? sq_rise : ZERO_BYTE;
            sq_fall_mv_o <= hs_mode_i ? sq_fall : ZERO_BYTE;
            eq_gain_o <= hs_mode_i ? eq_code : ZERO_CODE;
        end
    end

    // history restarts when high speed drops so a new packet starts at full swing
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_bit <= 1'b0;
            have_prev <= 1'b0;
        end else if (ce_i) begin
            if (!hs_mode_i) begin
                have_prev <= 1'b0;
            end else if (tx_bit_valid_i) begin
                prev_bit <= tx_bit_i;
                have_prev <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_deemph_o <= 1'b0;
            deemph_db_o <= ZERO_CODE;
            deemph_dur_o <= DUR_NONE;
        end else if (ce_i) begin
            deemph_dur_o <= dur_valid ? dur_code : DUR_NONE;
            if (!hs_mode_i) begin
                tx_deemph_o <= 1'b0;
                deemph_db_o <= ZERO_CODE;
            end else if (tx_bit_valid_i) begin
                tx_deemph_o <= next_deemph;
                deemph_db_o <= next_deemph ? lvl_code : ZERO_CODE;
            end
        end
    end

    // top trip level held apart from the lookup so a table slip is caught
    localparam logic [2:0] SQ_TOP_CODE = 3'h7;
    localparam logic [7:0] SQ_TOP_MV = 8'h9B;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // register bank
    chk_rx_write_masked: assert property (
        wr_rx |=> rx_tuning == ($past(reg_wdata_i) & RX_WRITE_MASK))
        else $error("rx tuning register stored a reserved bit");
    chk_tx_write_masked: assert property (
        wr_tx |=> tx_emphasis == ($past(reg_wdata_i) & TX_WRITE_MASK))
        else $error("tx emphasis register stored a reserved bit");
    chk_rx_write_only: assert property (
        !wr_rx |=> $stable(rx_tuning))
        else $error("rx tuning register changed without a write");
    chk_tx_write_only: assert property (
        !wr_tx |=> $stable(tx_emphasis))
        else $error("tx emphasis register changed without a write");
    chk_rdata_reserved: assert property (
        (reg_rdata_o & ~RX_WRITE_MASK) == ZERO_BYTE)
        else $error("reserved bit read back as one");
    chk_tx_rdata_reserved: assert property (
        ce_i && reg_rd_i && tx_sel |=> (reg_rdata_o & ~TX_WRITE_MASK) == ZERO_BYTE)
        else $error("reserved tx emphasis bit read back as one");
    chk_unmapped_read: assert property (
        ce_i && reg_rd_i && !rx_sel && !tx_sel |=> reg_rdata_o == ZERO_BYTE)
        else $error("unmapped address did not read zero");
    chk_rdata_holds: assert property (
        !(ce_i && reg_rd_i) |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    // rx side
    chk_squelch_hyst: assert property (
        sq_rise_mv_o > SQ_HYST_MV |-> sq_rise_mv_o - sq_fall_mv_o == SQ_HYST_MV)
        else $error("squelch hysteresis is not 10 mV");
    chk_squelch_fall_zero: assert property (
        sq_rise_mv_o == ZERO_BYTE |-> sq_fall_mv_o == ZERO_BYTE)
        else $error("falling trip set without a rising trip");
    chk_squelch_top: assert property (
        ce_i && hs_mode_i && sq_code == SQ_TOP_CODE |=> sq_rise_mv_o == SQ_TOP_MV)
        else $error("squelch code 111 is not 155 mV");
    chk_rx_ls_fs: assert property (
        ce_i && !hs_mode_i |=> eq_gain_o == ZERO_CODE && sq_rise_mv_o == ZERO_BYTE)
        else $error("rx settings leaked outside high speed");
    chk_eq_follows: assert property (
        ce_i && hs_mode_i |=> eq_gain_o == $past(eq_code))
        else $error("equalization gain does not follow its field");

    // tx side: a bit is reduced only when it repeats the one before it
    // the first bit after high speed entry has no history and goes at full swing
    chk_alternate_full: assert property (
        ce_i && hs_mode_i && tx_bit_valid_i && have_prev && tx_bit_i != prev_bit
        |=> !tx_deemph_o && deemph_db_o == ZERO_CODE)
        else $error("alternating bit was de-emphasised");
    chk_repeat_reduced: assert property (
        ce_i && hs_mode_i && tx_bit_valid_i && repeat_bit && dur_valid && lvl_valid
        |=> tx_deemph_o && deemph_db_o == $past(lvl_code))
        else $error("repeated bit was not reduced by the level");
    chk_first_bit_full: assert property (
        ce_i && hs_mode_i && tx_bit_valid_i && !have_prev |=> !tx_deemph_o)
        else $error("first bit after high speed entry was de-emphasised");
    chk_level_off: assert property (
        ce_i && hs_mode_i && tx_bit_valid_i && !lvl_valid |=> !tx_deemph_o)
        else $error("zero or undefined level still reduced the swing");
    chk_duration_off: assert property (
        ce_i && hs_mode_i && tx_bit_valid_i && !dur_valid |=> !tx_deemph_o)
        else $error("zero or reserved duration still reduced the swing");
    chk_full_swing_db: assert property (
        !tx_deemph_o |-> deemph_db_o == ZERO_CODE)
        else $error("level reported on a full swing bit");
    chk_hs_exit_clear: assert property (
        ce_i && !hs_mode_i |=> !tx_deemph_o && deemph_db_o == ZERO_CODE && !have_prev)
        else $error("de-emphasis or bit history survived high speed exit");
    chk_dur_reserved: assert property (
        deemph_dur_o != DUR_RESERVED)
        else $error("reserved duration code reached the driver");

    // clock enable
    chk_freeze: assert property (
        !ce_i |=> $stable(rx_tuning) && $stable(tx_emphasis) && $stable(prev_bit)
            && $stable(have_prev))
        else $error("state moved while clock enable was low");
    chk_freeze_outputs: assert property (
        !ce_i |=> $stable(reg_rdata_o) && $stable(sq_rise_mv_o) && $stable(sq_fall_mv_o)
            && $stable(eq_gain_o) && $stable(tx_deemph_o) && $stable(deemph_db_o)
            && $stable(deemph_dur_o))
        else $error("output moved while clock enable was low");

    cov_rx_write: cover property (wr_rx ##1 reg_rd_i && rx_sel && ce_i);
    cov_repeat_reduced: cover property (tx_deemph_o && deemph_db_o == LVL_MAX_CODE);
    cov_alternate: cover property (tx_deemph_o ##1 !tx_deemph_o && hs_mode_i);
    cov_hs_exit: cover property (hs_mode_i ##1 !hs_mode_i);
    cov_ce_freeze: cover property (!ce_i ##1 !ce_i);
endmodule

/* verification/test_usb2_hs_rx_tx_tuning_regs.sv */
// Purpose: self-checking bench for the usb2 hs rx/tx tuning registers
// Assumes: ce_i high except in the freeze scenario; inputs change by nba on the rising edge
// Notes: expectations come from the bench's own tables, not the package function
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_usb2_hs_rx_tx_tuning_regs;
    import usb2_tuning_pkg::*;
    logic mclk_i = 0, rst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic hs_mode_i = 1, tx_bit_i = 0, tx_bit_valid_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o, sq_rise_mv_o, sq_fall_mv_o;
    logic [2:0] eq_gain_o, deemph_db_o;
    logic [1:0] deemph_dur_o;
    logic tx_deemph_o;
    int err_total = 0;
    int total_checks = 0;
    int sq_tab [8] = '{0, 65, 85, 95, 110, 125, 140, 155};
    usb2_hs_rx_tx_tuning_regs i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .hs_mode_i(hs_mode_i),
        .tx_bit_i(tx_bit_i), .tx_bit_valid_i(tx_bit_valid_i), .sq_rise_mv_o(sq_rise_mv_o),
        .sq_fall_mv_o(sq_fall_mv_o), .eq_gain_o(eq_gain_o), .deemph_dur_o(deemph_dur_o),
        .deemph_db_o(deemph_db_o), .tx_deemph_o(tx_deemph_o));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK(reg_rdata_o, e)
    endtask
    task automatic sb(input logic b);
        @(posedge mclk_i);
        tx_bit_i <= b;
        tx_bit_valid_i <= 1'b1;
        @(posedge mclk_i);
        tx_bit_valid_i <= 1'b0;
        #1;
    endtask
    task automatic t_reserved();
        rd(RX_TUNING_ADDR, 8'h50);
        rd(TX_EMPHASIS_ADDR, 8'h00);
        // reserved bits set, rx fields at codes 111 and 100, tx duration at reserved code 11
        wr(RX_TUNING_ADDR, 8'hFC);
        rd(RX_TUNING_ADDR, 8'h74);
        wr(TX_EMPHASIS_ADDR, 8'hFE);
        rd(TX_EMPHASIS_ADDR, 8'h36);
        wr(8'h08, 8'hAA);
        rd(8'h08, 8'h00);
        rd(RX_TUNING_ADDR, 8'h74);
    endtask
    task automatic t_squelch();
        logic [7:0] r;
        // squelch code 000 maps to 0 mV with no falling offset, so the sweep starts at 001
        for (int c = 1; c < 8; c++) begin
            wr(RX_TUNING_ADDR, {1'b0, 3'(c), 1'b0, 3'(c % 5)});
            @(posedge mclk_i);
            #1;
            r = 8'(sq_tab[c]);
            `CHK(sq_rise_mv_o, r)
            `CHK(sq_fall_mv_o, r - 8'd10)
            `CHK(eq_gain_o, 3'(c % 5))
        end
    endtask
    task automatic t_hs_gate();
        @(posedge mclk_i);
        hs_mode_i <= 1'b0;
        @(posedge mclk_i);
        @(posedge mclk_i);
        #1;
        `CHK(sq_rise_mv_o, 8'h00)
        `CHK(eq_gain_o, 3'h0)
        @(posedge mclk_i);
        hs_mode_i <= 1'b1;
        @(posedge mclk_i);
        @(posedge mclk_i);
        #1;
        `CHK(sq_rise_mv_o, 8'd155)
    endtask
    task automatic t_freeze();
        // a write and a high speed drop while ce_i is low must leave no trace
        @(posedge mclk_i);
        ce_i <= 1'b0;
        wr(RX_TUNING_ADDR, 8'h13);
        hs_mode_i <= 1'b0;
        @(posedge mclk_i);
        @(posedge mclk_i);
        #1;
        `CHK(sq_rise_mv_o, 8'd155)
        `CHK(eq_gain_o, 3'h2)
        @(posedge mclk_i);
        hs_mode_i <= 1'b1;
        ce_i <= 1'b1;
        rd(RX_TUNING_ADDR, 8'h72);
    endtask
    task automatic t_deemph();
        logic on;
        for (int d = 0; d < 4; d++) begin
            for (int l = 0; l < 7; l++) begin
                wr(TX_EMPHASIS_ADDR, {2'b00, 2'(d), 1'b0, 3'(l)});
                @(posedge mclk_i);
                #1;
                `CHK(deemph_dur_o, (d == 3) ? 2'h0 : 2'(d))
                on = (d == 1 || d == 2) && l > 0 && l < 7;
                sb(1'b1);
                sb(1'b1);
                `CHK(tx_deemph_o, on)
                `CHK(deemph_db_o, on ? 3'(l) : 3'h0)
                sb(1'b0);
                `CHK(tx_deemph_o, 1'b0)
                `CHK(deemph_db_o, 3'h0)
            end
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // generous bound: the whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        err_total++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        `CHK(sq_rise_mv_o, 8'd125)
        `CHK(sq_fall_mv_o, 8'd115)
        `CHK(eq_gain_o, 3'h0)
        t_reserved();
        t_squelch();
        t_hs_gate();
        t_freeze();
        t_deemph();
        close_out();
    end
endmodule
